/* verilog/psd_program_space_decoder.sv */
// Program and data space decoder with external chip selects and wait states.
// Assumes requesters hold a request until its acknowledge and config is on ref_clk.
`timescale 1ns/1ns

// Function
// - Lowest sixteen words hold five interrupt vectors.
// - Fetches 0010H-00FFH select internal ROM.
// - Shadow vectors may overlay lowest sixteen words.
// - Writing one to enable activates overlay.
// - Overlay enabled blocks data access to shadows.
// - Five internal shadow vector registers exist.
// - 1000H selects shared 2K internal RAM.
// - Bank to 3FFFH: RAM if enabled, else ROM.
// - Bank 4000H-5FFFH RAM needs two banks.
// - Bank to 7FFFH RAM needs three banks.
// - Bank to 9FFFH RAM needs four banks.
// - Region to DFFFH selects external ROM.
// - Region to EFFFH selects external ROM.
// - F000H-FFFFH selects external ROM.
// - Two scratch memories are 256 words each.
// - Peripheral registers sit on one 256-word page.
// - Four external regions, each with own select.
// - Each external region has 0-3 wait states.
// - RAM, application, disk selects share pins.
// - External ROM and RAM span 56K words.
// - Bank select adds 8K RAM per step.
// - Disk region reads zero the upper byte.
// - D000H selects disk, C000H selects application.
module psd_program_space_decoder
	import psd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic prog_req,
	input wire logic [AW-1:0] prog_addr,
	input wire logic data_req,
	input wire logic data_wr,
	input wire logic [AW-1:0] data_addr,
	input wire logic [DW-1:0] data_wdata,
	input wire logic shadow_vec_en,
	input wire logic ext_ram_en,
	input wire logic [1:0] ram_bank_sel,
	input wire logic [WSW-1:0] rom_wait,
	input wire logic [WSW-1:0] ram_wait,
	input wire logic [WSW-1:0] app_wait,
	input wire logic [WSW-1:0] disk_wait,
	input wire logic ram_pin_sel,
	input wire logic app_pin_sel,
	input wire logic disk_pin_sel,
	input wire logic ram_pin_alt,
	input wire logic app_pin_alt,
	input wire logic disk_pin_alt,
	input wire logic [DW-1:0] ext_rdata,
	output logic prog_ack,
	output logic [DW-1:0] prog_rdata,
	output logic data_ack,
	output logic [DW-1:0] data_rdata,
	output logic int_rom_select,
	output logic int_ram_select,
	output logic shadow_select,
	output logic xram_select,
	output logic yram_select,
	output logic mmio_select,
	output logic ext_rom_select,
	output logic ext_ram_pin,
	output logic app_pin,
	output logic disk_pin,
	output logic [AW-1:0] ext_addr,
	output logic [DW-1:0] ext_wdata,
	output logic ext_data_oe,
	output logic ext_rd_n,
	output logic ext_wr_n
);

	psd_state_t state_ff;
	psd_state_t nxt_state;
	psd_tgt_t tgt_ff;
	psd_tgt_t nxt_tgt;
	logic is_prog_ff;
	logic nxt_is_prog;
	logic prog_ack_ff;
	logic nxt_prog_ack;
	logic [DW-1:0] prog_rdata_ff;
	logic [DW-1:0] nxt_prog_rdata;
	logic data_ack_ff;
	logic nxt_data_ack;
	logic [DW-1:0] data_rdata_ff;
	logic [DW-1:0] nxt_data_rdata;
	logic int_rom_select_ff;
	logic nxt_int_rom_select;
	logic int_ram_select_ff;
	logic nxt_int_ram_select;
	logic shadow_select_ff;
	logic nxt_shadow_select;
	logic xram_select_ff;
	logic nxt_xram_select;
	logic yram_select_ff;
	logic nxt_yram_select;
	logic mmio_select_ff;
	logic nxt_mmio_select;
	logic ext_rom_select_ff;
	logic nxt_ext_rom_select;
	logic ext_ram_select_ff;
	logic nxt_ext_ram_select;
	logic app_space_select_ff;
	logic nxt_app_space_select;
	logic disk_ctrl_select_ff;
	logic nxt_disk_ctrl_select;
	logic ext_ram_pin_ff;
	logic app_pin_ff;
	logic disk_pin_ff;
	logic [AW-1:0] ext_addr_ff;
	logic [AW-1:0] nxt_ext_addr;
	logic [DW-1:0] ext_wdata_ff;
	logic [DW-1:0] nxt_ext_wdata;
	logic ext_data_oe_ff;
	logic nxt_ext_data_oe;
	logic ext_rd_n_ff;
	logic nxt_ext_rd_n;
	logic ext_wr_n_ff;
	logic nxt_ext_wr_n;
	logic [DW-1:0] ext_rdata_s1_ff;
	logic [DW-1:0] ext_rdata_s2_ff;

	psd_tgt_t ptgt;
	psd_tgt_t dtgt;
	logic ws_start;
	logic [WSW-1:0] ws_load;
	logic ws_done;
	logic sv_wr;
	logic [DW-1:0] sv_data_rd;
	logic [DW-1:0] sv_prog_rd;

	// External banks 2000H-9FFFH become RAM one 8K step per bank select value.
	function automatic psd_tgt_t bank_tgt(input logic [AW-1:0] a, input logic en,
		input logic [1:0] sel);
		logic [1:0] idx;
		idx = 2'(a[BANK_MSB:BANK_LSB] - BANK_BASE);
		return (en && (idx <= sel)) ? TGT_ERAM : TGT_EROM;
	endfunction : bank_tgt

	function automatic psd_tgt_t prog_decode(input logic [AW-1:0] a, input logic sh_en,
		input logic en, input logic [1:0] sel);
		logic [3:0] slot;
		psd_tgt_t t;
		slot = psd_vec_slot(a[3:0]);
		t = TGT_NONE;
		if (a <= PA_VEC_HI)
		begin
			if (slot[3])
			begin
				t = sh_en ? TGT_SHADOW : TGT_IROM;
			end
			else
			begin
				t = TGT_NONE;
			end
		end
		else if (a <= PA_IROM_HI)
		begin
			t = TGT_IROM;
		end
		else if (a < PA_IRAM_LO)
		begin
			t = TGT_NONE;
		end
		else if (a <= PA_IRAM_HI)
		begin
			t = TGT_IRAM;
		end
		else if (a < PA_EXT_LO)
		begin
			t = TGT_NONE;
		end
		else if (a <= PA_BANK3_HI)
		begin
			t = bank_tgt(a, en, sel);
		end
		else if (a <= PA_ROMA_HI)
		begin
			t = TGT_EROM;
		end
		else if (a <= PA_ROMB_HI)
		begin
			t = TGT_EROM;
		end
		else
		begin
			t = TGT_EROM;
		end
		return t;
	endfunction : prog_decode

	function automatic psd_tgt_t data_decode(input logic [AW-1:0] a, input logic sh_en,
		input logic en, input logic [1:0] sel);
		psd_tgt_t t;
		t = TGT_NONE;
		if (a <= DA_XRAM_HI)
		begin
			t = TGT_XRAM;
		end
		else if ((a >= PA_IRAM_LO) && (a <= PA_IRAM_HI))
		begin
			t = TGT_IRAM;
		end
		else if ((a >= PA_EXT_LO) && (a <= PA_BANK3_HI))
		begin
			t = bank_tgt(a, en, sel);
		end
		else if ((a >= DA_APP_LO) && (a <= DA_APP_HI))
		begin
			t = TGT_APP;
		end
		else if ((a > DA_APP_HI) && (a <= DA_DISK_HI))
		begin
			t = TGT_DISK;
		end
		else if ((a >= DA_MMIO_LO) && (a <= DA_MMIO_HI))
		begin
			t = TGT_MMIO;
		end
		else if ((a >= DA_SHADOW_LO) && (a <= DA_SHADOW_HI))
		begin
			t = sh_en ? TGT_NONE : TGT_SHADOW;
		end
		else if (a >= DA_YRAM_LO)
		begin
			t = TGT_YRAM;
		end
		return t;
	endfunction : data_decode

	assign ptgt = prog_decode(prog_addr, shadow_vec_en, ext_ram_en, ram_bank_sel);
	assign dtgt = data_decode(data_addr, shadow_vec_en, ext_ram_en, ram_bank_sel);

	psd_shadow_vec #(
		.VEC_N(VEC_SLOTS)
	) u_shadow (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.wr_en(sv_wr),
		.data_addr(data_addr[3:0]),
		.wr_data(data_wdata),
		.data_rd(sv_data_rd),
		.prog_addr(prog_addr[3:0]),
		.prog_rd(sv_prog_rd)
	);

	psd_wait_timer u_wait (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(ws_start),
		.load(ws_load),
		.done(ws_done)
	);

	always_comb
	begin
		psd_tgt_t t;
		logic take_p;
		logic take_d;
		t = TGT_NONE;
		take_p = prog_req && !prog_ack_ff && !data_ack_ff;
		take_d = data_req && !take_p && !prog_ack_ff && !data_ack_ff;
		nxt_state = state_ff;
		nxt_tgt = tgt_ff;
		nxt_is_prog = is_prog_ff;
		nxt_prog_ack = 1'b0;
		nxt_prog_rdata = prog_rdata_ff;
		nxt_data_ack = 1'b0;
		nxt_data_rdata = data_rdata_ff;
		nxt_int_rom_select = 1'b0;
		nxt_int_ram_select = 1'b0;
		nxt_shadow_select = 1'b0;
		nxt_xram_select = 1'b0;
		nxt_yram_select = 1'b0;
		nxt_mmio_select = 1'b0;
		nxt_ext_rom_select = ext_rom_select_ff;
		nxt_ext_ram_select = ext_ram_select_ff;
		nxt_app_space_select = app_space_select_ff;
		nxt_disk_ctrl_select = disk_ctrl_select_ff;
		nxt_ext_addr = ext_addr_ff;
		nxt_ext_wdata = ext_wdata_ff;
		nxt_ext_data_oe = ext_data_oe_ff;
		nxt_ext_rd_n = ext_rd_n_ff;
		nxt_ext_wr_n = ext_wr_n_ff;
		ws_start = 1'b0;
		ws_load = rom_wait;
		sv_wr = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				t = take_p ? ptgt : dtgt;
				nxt_prog_ack = take_p;
				nxt_data_ack = take_d;
				nxt_is_prog = take_p;
				nxt_tgt = t;
				if (take_p && (t == TGT_SHADOW))
				begin
					nxt_prog_rdata = sv_prog_rd;
				end
				if (take_d)
				begin
					nxt_data_rdata = (t == TGT_SHADOW) ? sv_data_rd : '0;
					sv_wr = data_wr && (t == TGT_SHADOW);
				end
				if (take_p || take_d)
				begin
					nxt_shadow_select = (t == TGT_SHADOW);
					nxt_int_rom_select = (t == TGT_IROM);
					nxt_int_ram_select = (t == TGT_IRAM);
					nxt_xram_select = (t == TGT_XRAM);
					nxt_yram_select = (t == TGT_YRAM);
					nxt_mmio_select = (t == TGT_MMIO);
				end
				if ((take_p || take_d) && (t inside {TGT_EROM, TGT_ERAM, TGT_APP, TGT_DISK}))
				begin
					nxt_prog_ack = 1'b0;
					nxt_data_ack = 1'b0;
					nxt_state = ST_ACT;
					ws_start = 1'b1;
					case (t)
						TGT_ERAM: ws_load = ram_wait;
						TGT_APP: ws_load = app_wait;
						TGT_DISK: ws_load = disk_wait;
						default: ws_load = rom_wait;
					endcase
					nxt_ext_rom_select = (t == TGT_EROM);
					nxt_ext_ram_select = (t == TGT_ERAM);
					nxt_app_space_select = (t == TGT_APP);
					nxt_disk_ctrl_select = (t == TGT_DISK);
					nxt_ext_addr = take_p ? prog_addr : data_addr;
					nxt_ext_wdata = data_wdata;
					nxt_ext_data_oe = take_d && data_wr;
					nxt_ext_rd_n = !(take_p || !data_wr);
					nxt_ext_wr_n = !(take_d && data_wr);
				end
			end
			ST_ACT:
			begin
				if (ws_done)
				begin
					nxt_state = ST_IDLE;
					nxt_ext_rom_select = 1'b0;
					nxt_ext_ram_select = 1'b0;
					nxt_app_space_select = 1'b0;
					nxt_disk_ctrl_select = 1'b0;
					nxt_ext_data_oe = 1'b0;
					nxt_ext_rd_n = 1'b1;
					nxt_ext_wr_n = 1'b1;
					nxt_prog_ack = is_prog_ff;
					nxt_data_ack = !is_prog_ff;
					if (is_prog_ff)
					begin
						nxt_prog_rdata = ext_rdata_s2_ff;
					end
					else if (tgt_ff == TGT_DISK)
					begin
						nxt_data_rdata = {{(DW - DISK_BYTE_W){1'b0}},
							ext_rdata_s2_ff[DISK_BYTE_W-1:0]};
					end
					else
					begin
						nxt_data_rdata = ext_rdata_s2_ff;
					end
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_ff <= ST_IDLE;
			tgt_ff <= TGT_NONE;
			is_prog_ff <= 1'b0;
			prog_ack_ff <= 1'b0;
			prog_rdata_ff <= '0;
			data_ack_ff <= 1'b0;
			data_rdata_ff <= '0;
			int_rom_select_ff <= 1'b0;
			int_ram_select_ff <= 1'b0;
			shadow_select_ff <= 1'b0;
			xram_select_ff <= 1'b0;
			yram_select_ff <= 1'b0;
			mmio_select_ff <= 1'b0;
			ext_rom_select_ff <= 1'b0;
			ext_ram_select_ff <= 1'b0;
			app_space_select_ff <= 1'b0;
			disk_ctrl_select_ff <= 1'b0;
			ext_ram_pin_ff <= 1'b0;
			app_pin_ff <= 1'b0;
			disk_pin_ff <= 1'b0;
			ext_addr_ff <= '0;
			ext_wdata_ff <= '0;
			ext_data_oe_ff <= 1'b0;
			ext_rd_n_ff <= 1'b1;
			ext_wr_n_ff <= 1'b1;
			ext_rdata_s1_ff <= '0;
			ext_rdata_s2_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			tgt_ff <= nxt_tgt;
			is_prog_ff <= nxt_is_prog;
			prog_ack_ff <= nxt_prog_ack;
			prog_rdata_ff <= nxt_prog_rdata;
			data_ack_ff <= nxt_data_ack;
			data_rdata_ff <= nxt_data_rdata;
			int_rom_select_ff <= nxt_int_rom_select;
			int_ram_select_ff <= nxt_int_ram_select;
			shadow_select_ff <= nxt_shadow_select;
			xram_select_ff <= nxt_xram_select;
			yram_select_ff <= nxt_yram_select;
			mmio_select_ff <= nxt_mmio_select;
			ext_rom_select_ff <= nxt_ext_rom_select;
			ext_ram_select_ff <= nxt_ext_ram_select;
			app_space_select_ff <= nxt_app_space_select;
			disk_ctrl_select_ff <= nxt_disk_ctrl_select;
			ext_ram_pin_ff <= ram_pin_sel ? nxt_ext_ram_select : ram_pin_alt;
			app_pin_ff <= app_pin_sel ? nxt_app_space_select : app_pin_alt;
			disk_pin_ff <= disk_pin_sel ? nxt_disk_ctrl_select : disk_pin_alt;
			ext_addr_ff <= nxt_ext_addr;
			ext_wdata_ff <= nxt_ext_wdata;
			ext_data_oe_ff <= nxt_ext_data_oe;
			ext_rd_n_ff <= nxt_ext_rd_n;
			ext_wr_n_ff <= nxt_ext_wr_n;
			ext_rdata_s1_ff <= ext_rdata;
			ext_rdata_s2_ff <= ext_rdata_s1_ff;
		end
	end

	assign prog_ack = prog_ack_ff;
	assign prog_rdata = prog_rdata_ff;
	assign data_ack = data_ack_ff;
	assign data_rdata = data_rdata_ff;
	assign int_rom_select = int_rom_select_ff;
	assign int_ram_select = int_ram_select_ff;
	assign shadow_select = shadow_select_ff;
	assign xram_select = xram_select_ff;
	assign yram_select = yram_select_ff;
	assign mmio_select = mmio_select_ff;
	assign ext_rom_select = ext_rom_select_ff;
	assign ext_ram_pin = ext_ram_pin_ff;
	assign app_pin = app_pin_ff;
	assign disk_pin = disk_pin_ff;
	assign ext_addr = ext_addr_ff;
	assign ext_wdata = ext_wdata_ff;
	assign ext_data_oe = ext_data_oe_ff;
	assign ext_rd_n = ext_rd_n_ff;
	assign ext_wr_n = ext_wr_n_ff;

endmodule : psd_program_space_decoder

/* verilog/psd_pkg.sv */
// Constants, address map and types for the program space decoder.
// Assumes 16-bit program and data address spaces on one processor clock.
package psd_pkg;

	localparam int AW = 16;
	localparam int DW = 16;
	localparam int WSW = 2;
	localparam int VEC_SLOTS = 5;
	localparam int VEC_WORDS = 2;
	localparam int DISK_BYTE_W = 8;
	localparam int BANK_MSB = 15;
	localparam int BANK_LSB = 13;
	localparam int SLOT_MSB = 3;
	localparam int SLOT_LSB = 1;
	localparam logic [2:0] BANK_BASE = 3'h1;

	// Program space map.
	localparam logic [AW-1:0] PA_VEC_HI = 16'h000F;
	localparam logic [AW-1:0] PA_IROM_HI = 16'h00FF;
	localparam logic [AW-1:0] PA_IRAM_LO = 16'h1000;
	localparam logic [AW-1:0] PA_IRAM_HI = 16'h17FF;
	localparam logic [AW-1:0] PA_EXT_LO = 16'h2000;
	localparam logic [AW-1:0] PA_BANK3_HI = 16'h9FFF;
	localparam logic [AW-1:0] PA_ROMA_HI = 16'hDFFF;
	localparam logic [AW-1:0] PA_ROMB_HI = 16'hEFFF;

	// Data space map.
	localparam logic [AW-1:0] DA_XRAM_HI = 16'h00FF;
	localparam logic [AW-1:0] DA_APP_LO = 16'hC000;
	localparam logic [AW-1:0] DA_APP_HI = 16'hCFFF;
	localparam logic [AW-1:0] DA_DISK_HI = 16'hDFFF;
	localparam logic [AW-1:0] DA_MMIO_LO = 16'hE000;
	localparam logic [AW-1:0] DA_MMIO_HI = 16'hE0FF;
	localparam logic [AW-1:0] DA_SHADOW_LO = 16'hEF00;
	localparam logic [AW-1:0] DA_SHADOW_HI = 16'hEF0F;
	localparam logic [AW-1:0] DA_YRAM_LO = 16'hFF00;

	// Vector word-pair slots within the lowest sixteen words.
	localparam logic [2:0] SLOT_RESET = 3'h0;
	localparam logic [2:0] SLOT_BREAKPOINT = 3'h4;
	localparam logic [2:0] SLOT_TRAP = 3'h5;
	localparam logic [2:0] SLOT_INTERRUPT_ZERO = 3'h6;
	localparam logic [2:0] SLOT_INTERRUPT_ONE = 3'h7;

	localparam logic [DW-1:0] VEC_RESET_VAL = 16'h0000;

	typedef enum logic [3:0] {
		TGT_NONE = 4'h0,
		TGT_SHADOW = 4'h1,
		TGT_IROM = 4'h2,
		TGT_IRAM = 4'h3,
		TGT_EROM = 4'h4,
		TGT_ERAM = 4'h5,
		TGT_APP = 4'h6,
		TGT_DISK = 4'h7,
		TGT_XRAM = 4'h8,
		TGT_YRAM = 4'h9,
		TGT_MMIO = 4'hA
	} psd_tgt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACT = 2'b10
	} psd_state_t;

	// Returns valid flag and slot index for a vector word address.
	function automatic logic [3:0] psd_vec_slot(input logic [3:0] a);
		logic [3:0] r;
		r = 4'h0;
		case (a[SLOT_MSB:SLOT_LSB])
			SLOT_RESET: r = 4'h8;
			SLOT_BREAKPOINT: r = 4'h9;
			SLOT_TRAP: r = 4'hA;
			SLOT_INTERRUPT_ZERO: r = 4'hB;
			SLOT_INTERRUPT_ONE: r = 4'hC;
			default: r = 4'h0;
		endcase
		return r;
	endfunction : psd_vec_slot

endpackage : psd_pkg

/* verilog/psd_wait_timer.sv */
// Wait state counter for one external access.
// Assumes start is a one-cycle pulse from the decoder on the same clock.
`timescale 1ns/1ns
module psd_wait_timer
	import psd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [WSW-1:0] load,
	output logic done
);

	logic [WSW-1:0] cnt_ff;
	logic [WSW-1:0] nxt_cnt;
	logic run_ff;
	logic nxt_run;

	assign done = run_ff && (cnt_ff == '0);

	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		if (start)
		begin
			nxt_cnt = load;
			nxt_run = 1'b1;
		end
		else if (done)
		begin
			nxt_run = 1'b0;
		end
		else if (run_ff)
		begin
			nxt_cnt = cnt_ff - 2'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
		end
	end

endmodule : psd_wait_timer

/* verilog/psd_shadow_vec.sv */
// Shadow interrupt vector storage, written and read from data space.
// Assumes the decoder blocks data access while the overlay is enabled.
`timescale 1ns/1ns
module psd_shadow_vec
	import psd_pkg::*;
#(
	parameter int VEC_N = VEC_SLOTS
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [3:0] data_addr,
	input wire logic [DW-1:0] wr_data,
	output logic [DW-1:0] data_rd,
	input wire logic [3:0] prog_addr,
	output logic [DW-1:0] prog_rd
);

	localparam int NW = VEC_N * VEC_WORDS;

	if (VEC_N != VEC_SLOTS)
	begin : g_bad_vec_n
		$error("VEC_N must equal the number of vector slots.");
	end

	logic [DW-1:0] vec_ff [NW];
	logic [3:0] dslot;
	logic [3:0] pslot;
	logic [3:0] widx;

	assign dslot = psd_vec_slot(data_addr);
	assign pslot = psd_vec_slot(prog_addr);
	assign widx = {dslot[2:0], data_addr[0]};

	for (genvar e = 0; e < NW; e++)
	begin : g_vec
		logic [DW-1:0] nxt_vec;
		always_comb
		begin
			nxt_vec = vec_ff[e];
			if (wr_en && dslot[3] && (widx == 4'(e)))
			begin
				nxt_vec = wr_data;
			end
		end
		always_ff @(posedge ref_clk)
		begin
			if (!rstn)
			begin
				vec_ff[e] <= VEC_RESET_VAL;
			end
			else
			begin
				vec_ff[e] <= nxt_vec;
			end
		end
	end

	// Reserved words inside the window read as zero.
	assign data_rd = dslot[3] ? vec_ff[widx] : '0;
	assign prog_rd = pslot[3] ? vec_ff[{pslot[2:0], prog_addr[0]}] : '0;

endmodule : psd_shadow_vec

/* verif/psd_decoder_assertions.sv */
// Concurrent checks on the program space decoder's ports.
// Assumes requesters hold address and direction through the acknowledge cycle.
`timescale 1ns/1ns
module psd_decoder_assertions
	import psd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [AW-1:0] prog_addr,
	input wire logic data_wr,
	input wire logic [AW-1:0] data_addr,
	input wire logic shadow_vec_en,
	input wire logic prog_ack,
	input wire logic data_ack,
	input wire logic [DW-1:0] data_rdata,
	input wire logic int_rom_select,
	input wire logic int_ram_select,
	input wire logic shadow_select,
	input wire logic xram_select,
	input wire logic yram_select,
	input wire logic mmio_select,
	input wire logic ext_rom_select,
	input wire logic [AW-1:0] ext_addr,
	input wire logic ext_data_oe,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n
);
	logic [6:0] sels;

	assign sels = {int_rom_select, int_ram_select, shadow_select, xram_select, yram_select,
		mmio_select, ext_rom_select};

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// An external ROM access opens with ext_rom_select and closes within the wait budget.
	sequence s_ext_open;
		$rose(ext_rom_select);
	endsequence
	sequence s_ext_close;
		##[1:4] $fell(ext_rom_select);
	endsequence

	a_vec_rom: assert property (prog_ack && !shadow_vec_en && prog_addr inside {[16'h0008:16'h000F]}
		|-> int_rom_select) else $error("vector fetch missed internal ROM");
	a_rom_fetch: assert property (prog_ack && prog_addr inside {[16'h0010:16'h00FF]}
		|-> int_rom_select) else $error("internal ROM fetch not selected");
	a_vec_overlay: assert property (prog_ack && shadow_vec_en && prog_addr inside {[16'h0008:16'h000F]}
		|-> shadow_select && !int_rom_select) else $error("overlay fetch not shadowed");
	a_shadow_block: assert property (data_ack && shadow_vec_en && data_addr[15:4] == 12'hEF0
		|-> !shadow_select && (data_wr || data_rdata == 16'h0000)) else $error("shadow data open");
	a_iram_fetch: assert property (prog_ack && prog_addr[15:11] == 5'h02
		|-> int_ram_select) else $error("internal RAM fetch not selected");
	a_scratch_sel: assert property (data_ack |-> xram_select == (data_addr[15:8] == 8'h00)
		&& yram_select == (data_addr[15:8] == 8'hFF)) else $error("scratch select wrong");
	a_mmio_page: assert property (data_ack |-> mmio_select == (data_addr[15:8] == 8'hE0))
		else $error("peripheral page select wrong");
	a_rsvd_quiet: assert property (prog_ack && prog_addr inside {[16'h0100:16'h0FFF], [16'h1800:16'h1FFF]}
		|-> sels == 7'h00) else $error("reserved fetch raised a select");
	a_disk_byte: assert property (data_ack && !data_wr && data_addr[15:12] == 4'hD
		|-> data_rdata[15:8] == 8'h00) else $error("disk read upper byte not zero");
	a_ext_window: assert property (s_ext_open |-> s_ext_close)
		else $error("external select outlived three wait states");
	a_ext_ack: assert property ($fell(ext_rom_select) |-> prog_ack || data_ack)
		else $error("external access closed without acknowledge");
	a_sel_onehot: assert property ($onehot0(sels))
		else $error("two selects at once");
	a_strobe_excl: assert property (ext_rom_select |-> ext_rd_n != ext_wr_n)
		else $error("strobes not exclusive");
	a_oe_write: assert property (ext_data_oe |-> !ext_wr_n)
		else $error("data driven outside a write");
	a_addr_hold: assert property (!ext_rd_n && $past(ext_rd_n) == 1'b0 |-> $stable(ext_addr))
		else $error("address moved during read");
endmodule : psd_decoder_assertions

bind psd_program_space_decoder psd_decoder_assertions u_psd_decoder_assertions (.ref_clk, .rstn,
	.prog_addr, .data_wr, .data_addr, .shadow_vec_en, .prog_ack, .data_ack, .data_rdata,
	.int_rom_select, .int_ram_select, .shadow_select, .xram_select, .yram_select, .mmio_select,
	.ext_rom_select, .ext_addr, .ext_data_oe, .ext_rd_n, .ext_wr_n);

/* verif/psd_ext_mem_model.sv */
// Behavioural external memory and peripherals on the decoder's far side.
// Assumes active low strobes and an address that holds while a strobe is low.
`timescale 1ns/1ns
module psd_ext_mem_model #(
	parameter int DLY = 2
)
(
	input wire logic [15:0] ext_addr,
	input wire logic [15:0] ext_wdata,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	output logic [15:0] ext_rdata
);
	logic [15:0] mem [logic [15:0]];

	initial ext_rdata = 16'hFFFF;

	// Writes land while the write strobe is low on a plain address and data bus.
	always @(ext_wr_n, ext_addr, ext_wdata)
		if (!ext_wr_n)
			mem[ext_addr] = ext_wdata;

	// A released bus shows the inverse of its last value.
	always @(ext_rd_n, ext_addr)
		if (!ext_rd_n)
			ext_rdata <= #DLY mem.exists(ext_addr) ? mem[ext_addr] :
				{ext_addr[7:0] | 8'h80, ext_addr[15:8] ^ 8'h3C};
		else
			ext_rdata <= #DLY ~ext_rdata;
endmodule : psd_ext_mem_model

/* verif/tb_top.sv */
// Self-checking bench for the program space decoder.
// Assumes the external memory model answers on the decoder's far side.
`timescale 1ns/1ns
module tb_top;
	import psd_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, prog_req = 1'b0, data_req = 1'b0, data_wr = 1'b0;
	logic [15:0] prog_addr = 16'h0000, data_addr = 16'h0000, data_wdata = 16'h0000;
	logic shadow_vec_en = 1'b0, ext_ram_en = 1'b0;
	logic [1:0] ram_bank_sel = 2'h0, rom_wait = 2'h1, ram_wait = 2'h1, app_wait = 2'h1, disk_wait = 2'h1;
	logic ram_pin_sel = 1'b1, app_pin_sel = 1'b1, disk_pin_sel = 1'b1;
	logic ram_pin_alt = 1'b0, app_pin_alt = 1'b0, disk_pin_alt = 1'b0;
	logic [15:0] ext_rdata, prog_rdata, data_rdata, ext_addr, ext_wdata, r;
	logic prog_ack, data_ack, int_rom_select, int_ram_select, shadow_select, xram_select;
	logic yram_select, mmio_select, ext_rom_select, ext_ram_pin, app_pin, disk_pin;
	logic ext_data_oe, ext_rd_n, ext_wr_n;
	int miscompares = 0, n_compared = 0, seed = 61;
	logic [15:0] corners [26] = '{16'h0000, 16'h0002, 16'h0008, 16'h000E, 16'h0010, 16'h00FF,
		16'h0100, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000,
		16'h5FFF, 16'h6000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hDFFF, 16'hE000, 16'hEFF0,
		16'hEFF1, 16'hFFFF};
	logic [15:0] daddr [12] = '{16'hC000, 16'hCFFF, 16'hD000, 16'hDFFF, 16'h0000, 16'h00FF,
		16'hE000, 16'hE0FF, 16'hFF00, 16'hFFFF, 16'h1000, 16'hA000};
	logic [15:0] vec [5] = '{16'h0000, 16'h0008, 16'h000A, 16'h000C, 16'h000E};
	logic [15:0] sv [5];

	psd_program_space_decoder u_psd_program_space_decoder (.ref_clk, .rstn, .prog_req, .prog_addr,
		.data_req, .data_wr, .data_addr, .data_wdata, .shadow_vec_en, .ext_ram_en, .ram_bank_sel,
		.rom_wait, .ram_wait, .app_wait, .disk_wait, .ram_pin_sel, .app_pin_sel, .disk_pin_sel,
		.ram_pin_alt, .app_pin_alt, .disk_pin_alt, .ext_rdata, .prog_ack, .prog_rdata, .data_ack,
		.data_rdata, .int_rom_select, .int_ram_select, .shadow_select, .xram_select, .yram_select,
		.mmio_select, .ext_rom_select, .ext_ram_pin, .app_pin, .disk_pin, .ext_addr, .ext_wdata,
		.ext_data_oe, .ext_rd_n, .ext_wr_n);
	psd_ext_mem_model #(.DLY(2)) u_psd_ext_mem_model (.ext_addr, .ext_wdata, .ext_rd_n,
		.ext_wr_n, .ext_rdata);

	always #5 ref_clk = ~ref_clk;

	function automatic logic [15:0] pat(input logic [15:0] a);
		return {a[7:0] | 8'h80, a[15:8] ^ 8'h3C};
	endfunction : pat

	// Bits: irom iram shadow xram yram mmio erom eram app disk.
	function automatic logic [9:0] exp_sel(input logic p, input logic [15:0] a);
		if (p && a < 16'h0010)
			return (a[3:1] inside {3'h0, 3'h4, 3'h5, 3'h6, 3'h7}) ?
				(shadow_vec_en ? 10'h080 : 10'h200) : 10'h000;
		if (p && a < 16'h0100)
			return 10'h200;
		if (!p && a < 16'h0100)
			return 10'h040;
		if (a[15:11] == 5'h02)
			return 10'h100;
		if (a >= 16'h2000 && a < 16'hA000)
			return (ext_ram_en && a[15:13] - 3'h1 <= {1'b0, ram_bank_sel}) ? 10'h004 : 10'h008;
		if (p && a >= 16'hA000)
			return 10'h008;
		if (a[15:12] == 4'hC)
			return 10'h002;
		if (a[15:12] == 4'hD)
			return 10'h001;
		if (a[15:8] == 8'hE0)
			return 10'h010;
		if (a[15:4] == 12'hEF0)
			return shadow_vec_en ? 10'h000 : 10'h080;
		if (a[15:8] == 8'hFF)
			return 10'h020;
		return 10'h000;
	endfunction : exp_sel

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic cfg(input logic en, input logic [1:0] bs, input logic sh);
		@(negedge ref_clk);
		ext_ram_en = en;
		ram_bank_sel = bs;
		shadow_vec_en = sh;
		rom_wait = 2'h2 + 2'($unsigned($random(seed)) % 2);
		ram_wait = 2'h2 + 2'($unsigned($random(seed)) % 2);
		app_wait = 2'h2 + 2'($unsigned($random(seed)) % 2);
		disk_wait = 2'h2 + 2'($unsigned($random(seed)) % 2);
	endtask : cfg

	task automatic access(input logic p, input logic w, input logic [15:0] a, input logic [15:0] d);
		logic [9:0] es, seen;
		logic [1:0] ws;
		int n = 0, k = 0;
		es = exp_sel(p, a);
		ws = es[3] ? rom_wait : es[2] ? ram_wait : es[1] ? app_wait : disk_wait;
		seen = 10'h000;
		@(negedge ref_clk);
		{prog_addr, data_addr, data_wr, data_wdata, prog_req, data_req} = {a, a, w, d, p, !p};
		while (!(prog_ack || data_ack) && k < 50)
		begin
			@(negedge ref_clk);
			k++;
			seen |= {int_rom_select, int_ram_select, shadow_select, xram_select, yram_select,
				mmio_select, ext_rom_select, ext_ram_pin, app_pin, disk_pin};
			n += int'(ext_rom_select | ext_ram_pin | app_pin | disk_pin);
		end
		r = p ? prog_rdata : data_rdata;
		check(32'(prog_ack | data_ack), 32'h1);
		{prog_req, data_req} = 2'b00;
		check(32'(seen), 32'(es));
		if (es[3:0] != 4'h0)
			check(n, ws + 1);
	endtask : access

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		miscompares++;
		finish_test;
	end

	initial
	begin
		repeat (6) @(negedge ref_clk);
		check({prog_ack, data_ack, ext_rom_select, ext_data_oe, ext_rd_n, ext_wr_n}, 6'h03);
		rstn = 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			cfg(c[2], c[1:0], 1'b0);
			foreach (corners[i])
			begin
				access(1'b1, 1'b0, corners[i], 16'h0000);
				if (corners[i] >= 16'hA000)
					check(r, pat(corners[i]));
			end
		end
		$display("test program map done");
		for (int i = 0; i < 60; i++)
		begin
			cfg($random(seed), $random(seed), 1'b0);
			access(1'b1, 1'b0, $random(seed), 16'h0000);
			if (exp_sel(1'b1, prog_addr) & 10'h00C)
				check(r, pat(prog_addr));
		end
		$display("test random fetch done");
		foreach (daddr[i])
		begin
			access(1'b0, 1'b0, daddr[i], 16'h0000);
			if (daddr[i][15:13] == 3'h6)
				check(r, daddr[i][12] ? {8'h00, pat(daddr[i]) & 16'h00FF} : pat(daddr[i]));
		end
		cfg(1'b1, 2'h3, 1'b0);
		access(1'b0, 1'b1, 16'h2468, 16'hB00C);
		access(1'b0, 1'b0, 16'h2468, 16'h0000);
		check(r, 16'hB00C);
		$display("test data map done");
		foreach (vec[i])
		begin
			sv[i] = $random(seed);
			access(1'b0, 1'b1, 16'hEF00 | vec[i], sv[i]);
		end
		cfg(1'b1, 2'h3, 1'b1);
		foreach (vec[i])
		begin
			access(1'b1, 1'b0, vec[i], 16'h0000);
			check(r, sv[i]);
			access(1'b0, 1'b1, 16'hEF00 | vec[i], 16'h1234);
			access(1'b0, 1'b0, 16'hEF00 | vec[i], 16'h0000);
			check(r, 16'h0000);
		end
		cfg(1'b1, 2'h3, 1'b0);
		access(1'b0, 1'b0, 16'hEF08, 16'h0000);
		check(r, sv[1]);
		$display("test shadow vectors done");
		@(negedge ref_clk);
		{ram_pin_sel, app_pin_sel, disk_pin_sel} = 3'b000;
		{ram_pin_alt, app_pin_alt, disk_pin_alt} = 3'b101;
		repeat (3) @(negedge ref_clk);
		check({ext_ram_pin, app_pin, disk_pin}, 3'b101);
		$display("test pin sharing done");
		finish_test;
	end
endmodule : tb_top
